// file: cana_accept_irq.sv
// Behaviour
// - One CPU interrupt line, raised by any center's tx/rx event or errors.
// - Center flag set by tx success with tx enable, rx success with rx enable.
// - Hardware never clears a center flag; only a software write does.
// - Center flags are ORed into the single controller interrupt source.
// - Request reaches the CPU only with global and CAN enables both set.
// - Error and status events latch only while their enable bits are set.
// - Acceptance starts only for frames received free of bit errors.
// - Ready centers tested 1 to 15; first passing center takes frame.
// - Compare 11 bits for standard, 29 bits for extended, against arbitration.
// - Mask enable off means exact match; on compares only global mask ones.
// - Center 15 with mask on uses own mask ANDed with global mask.
// - Media filter compares data bytes 1-2 with media bytes under mask.
// - Frame loads only when every enabled test for the center passes.
// - Format selects transmit or receive and a data length of 0 to 8.
// - Center 15 is receive only, never transmits.
// - On lost arbitration or error, reload lowest-numbered pending transmitter.
// - Unread center 1 to 14 with overwrite off discards the new frame.
// - For centers 1 to 14, overwrite on replaces stored data and sets receive-overwrite flag.
// - Center 15 unread: next matching frame goes to one-entry holding buffer.
// - After software clears center 15 flags, held frame moves to visible.
// - Third frame: discarded if overwrite off, else replaces held frame only.
`timescale 1ns/1ps
`include "cana_map.svh"

module cana_accept_irq
    import cana_pkg::*;
#(
    parameter int NC = `CANA_NUM_CENTERS
) (
    input  wire logic        clock,            // System clock
    input  wire logic        reset_n,          // Async reset, active low
    input  wire logic        hsel,             // AHB slave select
    input  wire logic [31:0] haddr,            // AHB address
    input  wire logic [1:0]  htrans,           // AHB transfer type
    input  wire logic        hwrite,           // AHB write
    input  wire logic [2:0]  hsize,            // AHB size, word only
    input  wire logic [31:0] hwdata,           // AHB write data
    input  wire logic        hready,           // AHB bus ready
    output logic      [31:0] hrdata,           // AHB read data
    output logic             hreadyout,        // AHB slave ready
    output logic             hresp,            // AHB response, OKAY
    input  wire logic        rx_valid,         // Frame complete pulse
    input  wire logic        rx_bit_error,     // Frame had bit errors
    input  wire cana_frame_t rx_frame,         // Received frame
    input  wire logic        tx_done,          // Transmit success pulse
    input  wire logic [3:0]  tx_center,        // Center that transmitted
    input  wire logic        arb_lost,         // Arbitration lost pulse
    input  wire logic        err_event,        // Error condition pulse
    input  wire logic        status_event,     // Status change pulse
    output logic             can_irq,          // CPU interrupt request
    output logic             tx_reload,        // Reload transmit buffer
    output logic [3:0]       tx_reload_center, // Center to reload, 1..14
    output logic             rx_accept,        // Frame matched a center
    output logic [3:0]       rx_center         // Matching center, 1..15
);

    function automatic logic [4:0] cidx(input logic [11:0] a,
                                        input logic [11:0] base);
        logic [11:0] off;
        off = a - base;
        cidx = (off[11:2] < 10'(NC) && off[1:0] == 2'b00) ?
               {1'b1, off[5:2]} : 5'h00;
    endfunction
    function automatic logic [5:0] didx(input logic [11:0] a);
        logic [11:0] off;
        off = a - `CANA_A_DATA;
        didx = (off[11:3] < 9'(NC) && off[1:0] == 2'b00) ?
               {1'b1, off[6:3], off[2]} : 6'h00;
    endfunction
    function automatic logic [63:0] dmask(input logic [3:0] dlc);
        for (int b = 0; b < 8; b++) begin
            dmask[b*8 +: 8] = (4'(b) < dlc && 4'(b) < `CANA_DLC_MAX) ?
                              8'hFF : 8'h00;
        end
    endfunction
    function automatic logic id_hit(input cana_frame_t f,
                                    input logic [28:0] arb,
                                    input cana_cfg_t   c,
                                    input logic [28:0] m);
        logic [28:0] msk;
        msk = c.id_mask_enable ? m : 29'h1FFFFFFF;
        if (!c.ext) msk = msk & `CANA_STD_MASK;
        id_hit = (f.ext == c.ext) && (((f.id ^ arb) & msk) == 29'h0);
    endfunction

    logic [3:0]  ctrl_q;
    logic        err_q, stat_q;
    logic [28:0] gmask_q, m15mask_q;
    logic [31:0] media_q;
    cana_cfg_t   cfg_q   [NC];
    logic [28:0] arb_q   [NC];
    logic [63:0] data_q  [NC];
    logic [63:0] hold_q;
    logic        hold_v_q;
    logic [NC-1:0] irq_q, data_updated_flag_q, row_q, external_request_flag_q;
    logic        wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [3:0]  sel_q;

    logic          take, acc, media_ok, move15, hold_wr, any_pend;
    logic [3:0]    sel, pend_sel;
    logic [NC-1:0] hit, pend, vis_wr, ovw, irq_set, cc_wr;
    logic [4:0]    wci, wai, rci, rai;
    logic [5:0]    wdi, rdi;
    logic [31:0]   rd_word;

    assign take = hsel & hready & htrans[1];
    assign media_ok = ((rx_frame.data[23:8] ^ media_q[15:0])
                       & media_q[31:16]) == 16'h0000;

    // Acceptance test of each center
    generate
        for (genvar i = 0; i < NC; i++) begin : g_hit
            logic [28:0] m;
            assign m = (i == NC-1) ? (m15mask_q & gmask_q)
                                   : gmask_q;
            assign hit[i] = cfg_q[i].ready & ~cfg_q[i].dir
                          & id_hit(rx_frame, arb_q[i], cfg_q[i], m)
                          & (~cfg_q[i].media_filter_enable | media_ok);
            assign pend[i] = (i != NC-1) & cfg_q[i].ready
                           & cfg_q[i].dir;
        end
    endgenerate

    // Lowest-numbered center wins
    always_comb begin
        sel = 4'h0;
        pend_sel = 4'h0;
        for (int k = NC-1; k >= 0; k--) begin
            if (hit[k]) sel = 4'(k);
            if (pend[k]) pend_sel = 4'(k);
        end
        any_pend = |pend;
        acc = rx_valid & ~rx_bit_error & (|hit);
    end

    always_comb begin
        vis_wr = '0;
        ovw = '0;
        irq_set = '0;
        wci = cidx(wr_addr_q, `CANA_A_CCTL);
        wai = cidx(wr_addr_q, `CANA_A_ARB);
        wdi = didx(wr_addr_q);
        for (int i = 0; i < NC-1; i++) begin
            vis_wr[i] = acc && sel == 4'(i)
                      && (!data_updated_flag_q[i] || cfg_q[i].ow);
            ovw[i] = acc && sel == 4'(i)
                   && data_updated_flag_q[i] && cfg_q[i].ow;
        end
        move15 = hold_v_q & ~data_updated_flag_q[NC-1] & ~irq_q[NC-1]
               & ~external_request_flag_q[NC-1];
        hold_wr = acc && sel == 4'(NC-1)
                && (data_updated_flag_q[NC-1] || hold_v_q)
                && (!hold_v_q || move15 || cfg_q[NC-1].ow);
        vis_wr[NC-1] = move15 || (acc && sel == 4'(NC-1)
                     && !data_updated_flag_q[NC-1] && !hold_v_q);
        ovw[NC-1] = acc && sel == 4'(NC-1) && hold_v_q
                  && !move15 && cfg_q[NC-1].ow;
        for (int i = 0; i < NC; i++) begin
            irq_set[i] = (vis_wr[i] & cfg_q[i].rxie)
                       | (tx_done && tx_center == 4'(i + 1)
                          && cfg_q[i].dir && cfg_q[i].txie);
            cc_wr[i] = wr_pend_q && wci == {1'b1, 4'(i)};
        end
    end

    // Bus address phase: latch write target, prepare read data
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
            hrdata    <= `CANA_RST_WORD;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= take & hwrite;
            wr_addr_q <= haddr[11:0];
            hrdata    <= (take & ~hwrite) ? rd_word : `CANA_RST_WORD;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_comb begin
        rd_word = `CANA_RST_WORD;
        rci = cidx(haddr[11:0], `CANA_A_CCTL);
        rai = cidx(haddr[11:0], `CANA_A_ARB);
        rdi = didx(haddr[11:0]);
        case (haddr[11:0])
            `CANA_A_CTRL:    rd_word = {28'h0, ctrl_q};
            `CANA_A_EVT:     rd_word = {29'h0, can_irq, stat_q, err_q};
            `CANA_A_GMASK:   rd_word = {3'h0, gmask_q};
            `CANA_A_M15MASK: rd_word = {3'h0, m15mask_q};
            `CANA_A_MEDIA:   rd_word = media_q;
            `CANA_A_TXSEL:   rd_word = {27'h0, any_pend, pend_sel + 4'h1};
            default: begin
                if (rci[4]) begin
                    rd_word = {11'h0,
                               (rci[3:0] == 4'(NC-1)) & hold_v_q,
                               external_request_flag_q[rci[3:0]], row_q[rci[3:0]],
                               data_updated_flag_q[rci[3:0]], irq_q[rci[3:0]],
                               4'h0, cfg_q[rci[3:0]]};
                end else if (rai[4]) begin
                    rd_word = {3'h0, arb_q[rai[3:0]]};
                end else if (rdi[5]) begin
                    rd_word = rdi[0] ? data_q[rdi[4:1]][63:32]
                                     : data_q[rdi[4:1]][31:0];
                end
            end
        endcase
    end

    // Global control, masks and media filter
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q    <= 4'h0;
            gmask_q   <= 29'h0;
            m15mask_q <= 29'h0;
            media_q   <= `CANA_RST_WORD;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                `CANA_A_CTRL:    ctrl_q    <= hwdata[3:0];
                `CANA_A_GMASK:   gmask_q   <= hwdata[28:0];
                `CANA_A_M15MASK: m15mask_q <= hwdata[28:0];
                `CANA_A_MEDIA:   media_q   <= hwdata;
                default:         ctrl_q    <= ctrl_q;
            endcase
        end
    end

    // Per-center format and arbitration
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NC; i++) begin
                cfg_q[i] <= cana_cfg_t'(12'h000);
                arb_q[i] <= 29'h0;
            end
        end else begin
            for (int i = 0; i < NC; i++) begin
                if (cc_wr[i]) cfg_q[i] <= cana_cfg_t'(hwdata[11:0]);
                if (wr_pend_q && wai == {1'b1, 4'(i)})
                    arb_q[i] <= hwdata[28:0];
            end
            if (cc_wr[NC-1]) cfg_q[NC-1].dir <= 1'b0;
        end
    end

    // Center flags: set wins over software clear
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_q   <= '0;
            data_updated_flag_q  <= '0;
            row_q   <= '0;
            external_request_flag_q <= '0;
        end else begin
            for (int i = 0; i < NC; i++) begin
                irq_q[i] <= irq_set[i] | (irq_q[i]
                    & ~(cc_wr[i] & hwdata[`CANA_CC_IRQ]));
                data_updated_flag_q[i] <= vis_wr[i] | (data_updated_flag_q[i]
                    & ~(cc_wr[i] & hwdata[`CANA_CC_DATA_UPDATED_FLAG]));
                row_q[i] <= ovw[i] | (row_q[i]
                    & ~(cc_wr[i] & hwdata[`CANA_CC_ROW]));
                if (cc_wr[i]) external_request_flag_q[i] <= hwdata[`CANA_CC_EXTERNAL_REQUEST_FLAG];
            end
        end
    end

    // Message data and center 15 holding buffer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NC; i++) begin
                data_q[i] <= 64'h0;
            end
            hold_q   <= 64'h0;
            hold_v_q <= 1'b0;
        end else begin
            if (wr_pend_q && wdi[5])
                data_q[wdi[4:1]][wdi[0]*32 +: 32] <= hwdata;
            for (int i = 0; i < NC-1; i++) begin
                if (vis_wr[i]) begin
                    data_q[i] <= (data_q[i] & ~dmask(cfg_q[i].dlc))
                        | (rx_frame.data & dmask(cfg_q[i].dlc));
                end
            end
            if (move15) begin
                data_q[NC-1] <= hold_q;
            end else if (vis_wr[NC-1]) begin
                data_q[NC-1] <= rx_frame.data & dmask(cfg_q[NC-1].dlc);
            end
            if (hold_wr) begin
                hold_q <= rx_frame.data & dmask(cfg_q[NC-1].dlc);
            end
            hold_v_q <= hold_wr | (hold_v_q & ~move15);
        end
    end

    // Error/status events and the interrupt line
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            err_q   <= 1'b0;
            stat_q  <= 1'b0;
            can_irq <= 1'b0;
        end else begin
            err_q <= (err_event & ctrl_q[`CANA_CTRL_ERRIE])
                   | (err_q & ~(wr_pend_q && wr_addr_q == `CANA_A_EVT
                                && hwdata[`CANA_EVT_ERR]));
            stat_q <= (status_event & ctrl_q[`CANA_CTRL_STATUS_IRQ_ENABLE])
                    | (stat_q & ~(wr_pend_q && wr_addr_q == `CANA_A_EVT
                                  && hwdata[`CANA_EVT_STAT]));
            can_irq <= ((|irq_q) | err_q | stat_q)
                     & ctrl_q[`CANA_CTRL_CANIE]
                     & ctrl_q[`CANA_CTRL_GIE];
        end
    end

    // Acceptance report and transmit reload
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_accept        <= 1'b0;
            rx_center        <= 4'h0;
            sel_q            <= 4'h0;
            tx_reload        <= 1'b0;
            tx_reload_center <= 4'h0;
        end else begin
            rx_accept <= acc;
            rx_center <= acc ? sel + 4'h1 : 4'h0;
            sel_q     <= sel;
            tx_reload <= (arb_lost | err_event) & any_pend;
            tx_reload_center <= pend_sel + 4'h1;
        end
    end

    a_irq_gate: assert property (@(posedge clock) disable iff (!reset_n)
        can_irq |-> $past(ctrl_q[`CANA_CTRL_CANIE] & ctrl_q[`CANA_CTRL_GIE]))
        else $error("interrupt raised while disabled");
    a_flag_sticky: assert property (@(posedge clock) disable iff (!reset_n)
        (($past(irq_q) & ~irq_q) != '0) |-> $past(|cc_wr))
        else $error("center flag cleared without write");
    a_rx_clean: assert property (@(posedge clock) disable iff (!reset_n)
        rx_accept |-> $past(rx_valid & ~rx_bit_error))
        else $error("frame accepted with bit error");
    a_first_center: assert property (@(posedge clock) disable iff (!reset_n)
        rx_accept |-> ($past(hit)
            & ((15'h0001 << (rx_center - 4'h1)) - 15'h0001)) == 15'h0)
        else $error("lower center skipped");
    a_no_tx15: assert property (@(posedge clock) disable iff (!reset_n)
        tx_reload |-> tx_reload_center != 4'(NC) && !cfg_q[NC-1].dir)
        else $error("center 15 chosen to transmit");
    a_discard_keep: assert property (@(posedge clock) disable iff (!reset_n)
        (acc && sel != 4'(NC-1) && data_updated_flag_q[sel] && !cfg_q[sel].ow)
        |=> data_q[sel_q] == $past(data_q[sel]))
        else $error("unread data overwritten");
    a_ovw_flag: assert property (@(posedge clock) disable iff (!reset_n)
        (acc && sel != 4'(NC-1) && data_updated_flag_q[sel] && cfg_q[sel].ow)
        |=> row_q[sel_q])
        else $error("overwrite flag not set");
    a_hold_fill: assert property (@(posedge clock) disable iff (!reset_n)
        (acc && sel == 4'(NC-1) && data_updated_flag_q[NC-1] && !hold_v_q)
        |=> hold_v_q && data_q[NC-1] == $past(data_q[NC-1]))
        else $error("second frame not held");
    a_hold_move: assert property (@(posedge clock) disable iff (!reset_n)
        move15 |=> data_updated_flag_q[NC-1] ##0 data_q[NC-1] == $past(hold_q))
        else $error("held frame not moved");
    a_err_gate: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(err_q) |-> $past(ctrl_q[`CANA_CTRL_ERRIE]))
        else $error("error flag set while disabled");

endmodule // cana_accept_irq

// file: cana_map.svh
`ifndef CANA_MAP_SVH
`define CANA_MAP_SVH

// Register byte offsets (low 12 address bits)
`define CANA_A_CTRL      12'h000
`define CANA_A_EVT       12'h004
`define CANA_A_GMASK     12'h008
`define CANA_A_M15MASK   12'h00C
`define CANA_A_MEDIA     12'h010
`define CANA_A_TXSEL     12'h014
`define CANA_A_CCTL      12'h100
`define CANA_A_ARB       12'h140
`define CANA_A_DATA      12'h180

// Controller control bits
`define CANA_CTRL_ERRIE  0
`define CANA_CTRL_STATUS_IRQ_ENABLE   1
`define CANA_CTRL_CANIE  2
`define CANA_CTRL_GIE    3

// Event register bits
`define CANA_EVT_ERR     0
`define CANA_EVT_STAT    1

// Center control flag bits (config sits in [11:0])
`define CANA_CC_IRQ      16
`define CANA_CC_DATA_UPDATED_FLAG     17
`define CANA_CC_ROW      18
`define CANA_CC_EXTERNAL_REQUEST_FLAG    19

`define CANA_NUM_CENTERS 15
`define CANA_DLC_MAX     4'h8
`define CANA_STD_MASK    29'h1FFC0000
`define CANA_RST_WORD    32'h00000000

`endif

// file: cana_pkg.sv
package cana_pkg;

    typedef struct packed {
        logic [28:0] id;
        logic        ext;
        logic [63:0] data;
    } cana_frame_t;

    typedef struct packed {
        logic [3:0] dlc;
        logic       ow;
        logic       media_filter_enable;
        logic       id_mask_enable;
        logic       ext;
        logic       dir;
        logic       rxie;
        logic       txie;
        logic       ready;
    } cana_cfg_t;

endpackage

// file: cana_node.sv
`timescale 1ns/1ps

module cana_node
    import cana_pkg::*;
(
    input  wire logic   clock,        // System clock
    output logic        rx_valid,     // Frame complete pulse
    output logic        rx_bit_error, // Frame had bit errors
    output cana_frame_t rx_frame,     // Frame seen on the bus
    output logic        tx_done,      // Transmit success pulse
    output logic [3:0]  tx_center,    // Center that transmitted
    output logic        arb_lost,     // Arbitration lost pulse
    output logic        err_event,    // Error condition pulse
    output logic        status_event  // Status change pulse
);
    initial begin
        {rx_valid, rx_bit_error, tx_done, arb_lost} = 4'h0;
        {err_event, status_event, tx_center} = 6'h00;
        rx_frame = '0;
    end

    // Frame fields scrambled once the frame has ended
    task automatic frame(input cana_frame_t f, input logic b);
        @(posedge clock);
        rx_valid     <= 1'b1;
        rx_bit_error <= b;
        rx_frame     <= f;
        @(posedge clock);
        rx_valid     <= 1'b0;
        rx_bit_error <= ~b;
        rx_frame     <= ~f;
    endtask

    // Kind bits: tx done, arbitration lost, error, status
    task automatic pulse(input logic [3:0] k, input logic [3:0] c);
        @(posedge clock);
        {status_event, err_event, arb_lost, tx_done} <= k;
        tx_center <= c;
        @(posedge clock);
        {status_event, err_event, arb_lost, tx_done} <= 4'h0;
        tx_center <= ~c;
    endtask
endmodule // cana_node

// file: tb.sv
`timescale 1ns/1ps
`include "cana_map.svh"

module tb
    import cana_pkg::*;
;
    logic        clock, reset_n, hsel, hwrite, hresp, hreadyout;
    logic        rx_valid, rx_bit_error, tx_done, arb_lost, err_event;
    logic        status_event, can_irq, tx_reload, rx_accept;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  tx_center, tx_reload_center, rx_center;
    logic [31:0] haddr, hwdata, hrdata, rd, d0;
    logic [28:0] a, fid;
    logic [63:0] d;
    cana_frame_t rx_frame;
    int          bad_count, tests_run, seed, cyc, p;

    cana_accept_irq u_dut (
        .clock, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .rx_valid, .rx_bit_error, .rx_frame, .tx_done, .tx_center,
        .arb_lost, .err_event, .status_event, .can_irq, .tx_reload,
        .tx_reload_center, .rx_accept, .rx_center
    );

    cana_node u_node (
        .clock, .rx_valid, .rx_bit_error, .rx_frame, .tx_done,
        .tx_center, .arb_lost, .err_event, .status_event
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end

    function automatic logic [11:0] ca(int n);
        return 12'(`CANA_A_CCTL + 4 * (n - 1));
    endfunction
    function automatic logic [11:0] cr(int n);
        return 12'(`CANA_A_ARB + 4 * (n - 1));
    endfunction
    function automatic logic [11:0] cd(int n);
        return 12'(`CANA_A_DATA + 8 * (n - 1));
    endfunction
    function automatic logic hit(logic [28:0] x, logic [28:0] y, logic e);
        return ((x ^ y) & (e ? 29'h1FFFFFFF : `CANA_STD_MASK)) == 29'h0;
    endfunction

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask

    task automatic bus(logic w, logic [11:0] ad, logic [31:0] wd);
        @(posedge clock);
        htrans <= 2'b10;
        haddr  <= {20'h0, ad};
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdc(logic [11:0] ad, logic [31:0] e, string nm);
        bus(1'b0, ad, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic fr(logic [28:0] id, logic e, logic b, logic [3:0] c);
        u_node.frame({id, e, d}, b);
        @(negedge clock);
        chk("rx", {27'h0, |c, c}, {27'h0, rx_accept, rx_center});
    endtask

    task automatic ev(logic [3:0] k, logic [3:0] c, logic [4:0] e);
        u_node.pulse(k, c);
        @(negedge clock);
        chk("reload", {27'h0, e},
            {27'h0, tx_reload, tx_reload_center & {4{tx_reload}}});
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        seed = 16951;
        reset_n = 1'b0;
        hsel = 1'b1;
        {haddr, hwdata, htrans, hwrite, d0, d} = '0;
        hsize = 3'b010;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        @(negedge clock);
        chk("idle", 32'h4, {29'h0, hreadyout, hresp, can_irq});
        bus(1'b1, 12'hFFC, 32'hFFFFFFFF);
        rdc(12'hFFC, 32'h0, "unmapped");
        rdc(`CANA_A_CTRL, 32'h0, "ctrl");
        bus(1'b1, `CANA_A_CTRL, 32'hF);
        bus(1'b1, `CANA_A_GMASK, 32'h1FFFFFFF);
        for (int i = 0; i < 8; i++) begin
            a = 29'($random(seed));
            d = {$random(seed), $random(seed)};
            p = {$random(seed)} % 29;
            fid = (i < 2) ? a : a ^ (29'h1 << p);
            bus(1'b1, ca(2), 32'h30805 | {27'h0, i[0], 4'h0});
            bus(1'b1, cr(2), {3'h0, a});
            fr(a, i[0], 1'b1, 4'h0);
            fr(fid, i[0], 1'b0, hit(a, fid, i[0]) ? 4'h2 : 4'h0);
            if (hit(a, fid, i[0])) d0 = d[31:0];
            rdc(cd(2), d0, "data");
        end
        a = 29'h16940000;
        bus(1'b1, ca(1), 32'h805);
        bus(1'b1, ca(3), 32'h805);
        bus(1'b1, cr(1), {3'h0, a});
        bus(1'b1, cr(3), {3'h0, a});
        d = 64'h1;
        fr(a, 1'b0, 1'b0, 4'h1);
        fr(~a, 1'b0, 1'b0, 4'h0);
        rdc(ca(1), 32'h30805, "flags");
        d = 64'h2;
        fr(a, 1'b0, 1'b0, 4'h1);
        rdc(cd(1), 32'h1, "kept");
        bus(1'b1, ca(1), 32'h885);
        fr(a, 1'b0, 1'b0, 4'h1);
        rdc(cd(1), 32'h2, "overwrite");
        rdc(ca(1), 32'h70885, "row");
        bus(1'b1, `CANA_A_GMASK, 32'h1FEFFFFF);
        bus(1'b1, cr(4), 32'h01234567);
        bus(1'b1, ca(4), 32'h835);
        fr(29'h01334567, 1'b1, 1'b0, 4'h4);
        fr(29'h01034567, 1'b1, 1'b0, 4'h0);
        bus(1'b1, `CANA_A_M15MASK, 32'h1FFFFFDF);
        bus(1'b1, cr(15), 32'h0ABCDEF0);
        bus(1'b1, ca(15), 32'h83D);
        rdc(ca(15), 32'h835, "rx only");
        d = 64'h11;
        fr(29'h0AACDEF0, 1'b1, 1'b0, 4'hF);
        fr(29'h0ABCDEB0, 1'b1, 1'b0, 4'h0);
        d = 64'h22;
        fr(29'h0ABCDED0, 1'b1, 1'b0, 4'hF);
        rdc(cd(15), 32'h11, "visible");
        d = 64'h33;
        fr(29'h0ABCDEF0, 1'b1, 1'b0, 4'hF);
        bus(1'b1, ca(15), 32'h30835);
        rdc(cd(15), 32'h22, "moved");
        d = 64'h44;
        fr(29'h0ABCDEF0, 1'b1, 1'b0, 4'hF);
        bus(1'b1, ca(15), 32'h8B5);
        d = 64'h55;
        fr(29'h0ABCDEF0, 1'b1, 1'b0, 4'hF);
        rdc(cd(15), 32'h22, "untouched");
        bus(1'b1, ca(15), 32'h308B5);
        rdc(cd(15), 32'h55, "replaced");
        bus(1'b1, `CANA_A_MEDIA, 32'h0FFFC35A);
        bus(1'b1, cr(5), 32'h00200000);
        bus(1'b1, ca(5), 32'h845);
        d = 64'h00F35A00;
        fr(29'h00200000, 1'b0, 1'b0, 4'h5);
        d = 64'h00F45A00;
        fr(29'h00200000, 1'b0, 1'b0, 4'h0);
        bus(1'b1, cd(8), 32'hFFFFFFFF);
        bus(1'b1, cr(8), 32'h04000000);
        bus(1'b1, ca(8), 32'h205);
        d = 64'h12345678;
        fr(29'h04000000, 1'b0, 1'b0, 4'h8);
        rdc(cd(8), 32'hFFFF5678, "dlc");
        bus(1'b1, ca(6), 32'h80B);
        bus(1'b1, ca(7), 32'h80B);
        ev(4'h1, 4'h6, 5'h00);
        rdc(ca(6), 32'h1080B, "tx flag");
        ev(4'h2, 4'h0, 5'h16);
        ev(4'h4, 4'h0, 5'h16);
        rdc(`CANA_A_EVT, 32'h5, "err");
        bus(1'b1, `CANA_A_EVT, 32'h1);
        bus(1'b1, `CANA_A_CTRL, 32'hE);
        ev(4'h4, 4'h0, 5'h16);
        ev(4'h8, 4'h0, 5'h00);
        rdc(`CANA_A_EVT, 32'h6, "status");
        bus(1'b1, `CANA_A_CTRL, 32'h7);
        repeat (2) @(negedge clock);
        chk("gated", 32'h0, {31'h0, can_irq});
        bus(1'b1, `CANA_A_CTRL, 32'hF);
        repeat (2) @(negedge clock);
        chk("irq", 32'h1, {31'h0, can_irq});
        conclude();
    end
endmodule // tb
